/* File: logic/comms_watchdog.sv */
// communications-loss timer counted in tenths of a second
`timescale 1ns/1ps
module comms_watchdog #(
  parameter int unsigned UNIT_CYC = fieldbus_cfg_pkg::WDOG_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic kick,
  input wire logic [fieldbus_cfg_pkg::WDOG_W-1:0] period,
  output logic loss
);
  import fieldbus_cfg_pkg::*;
  localparam int CW = $clog2(UNIT_CYC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(UNIT_CYC - 1);

  logic [CW-1:0] cyc_q;
  logic [WDOG_W-1:0] units_q;
  logic loss_q;
  logic unitEnd;

  assign unitEnd = cyc_q == CYC_LAST;
  assign loss = loss_q;

  always_ff @(posedge clk) begin
    if (srst || kick || period == '0 || loss_q) begin
      cyc_q <= '0;
    end else if (unitEnd) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || kick || period == '0 || loss_q) begin
      units_q <= '0;
    end else if (unitEnd) begin
      units_q <= units_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || period == '0) begin
      loss_q <= 1'b0;
    end else if (kick) begin
      loss_q <= 1'b0;
    end else if (unitEnd && units_q + 1'b1 == period) begin
      loss_q <= 1'b1;
    end
  end
endmodule // comms_watchdog

/* File: logic/fieldbus_cfg_pkg.sv */
// shared constants and types for the fieldbus configuration link
package fieldbus_cfg_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned WDOG_UNIT_MS = 100;
  localparam int unsigned WDOG_UNIT_CYCLES = CLK_HZ / 1000 * WDOG_UNIT_MS;
  localparam int unsigned RSP_WAIT_NS = 128;
  localparam int unsigned RSP_WAIT_CYCLES = RSP_WAIT_NS / CLK_PERIOD_NS;

  localparam int ADDR_W = 6;
  localparam int RATE_W = 11;
  localparam int FRM_W = 2;
  localparam int WDOG_W = 6;
  localparam int LOSS_W = 2;
  localparam int SEL_W = 3;
  localparam int IDX_W = 4;
  localparam int KIND_W = 2;
  localparam int REG_W = 4;

  typedef logic [15:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [RATE_W-1:0] rate_t;

  localparam addr_t NODE_MAX = 6'h3F;
  localparam addr_t NODE_DEF = 6'h01;
  // can rate in kbps, serial rate in units of 100 bps
  localparam rate_t CAN_MIN = 11'h07D;
  localparam rate_t CAN_MAX = 11'h3E8;
  localparam rate_t CAN_DEF = 11'h1F4;
  localparam rate_t SER_MIN = 11'h060;
  localparam rate_t SER_MAX = 11'h480;
  localparam rate_t SER_DEF = 11'h480;

  localparam logic [FRM_W-1:0] FRM_NONE_1 = 2'h0;
  localparam logic [FRM_W-1:0] FRM_NONE_2 = 2'h1;
  localparam logic [FRM_W-1:0] FRM_ODD_1 = 2'h2;
  localparam logic [FRM_W-1:0] FRM_EVEN_1 = 2'h3;

  // watchdog period in tenths of a second
  localparam logic [WDOG_W-1:0] WDOG_MAX = 6'h32;
  localparam logic [WDOG_W-1:0] WDOG_DEF = 6'h14;

  localparam logic [LOSS_W-1:0] LOSS_TRIP_COAST = 2'h0;
  localparam logic [LOSS_W-1:0] LOSS_RAMP_TRIP = 2'h1;
  localparam logic [LOSS_W-1:0] LOSS_RAMP_ONLY = 2'h2;
  localparam logic [LOSS_W-1:0] LOSS_PRESET8 = 2'h3;

  localparam logic RAMP_INTERNAL = 1'b0;
  localparam logic RAMP_FIELDBUS = 1'b1;

  localparam logic [SEL_W-1:0] W4_TORQUE = 3'h0;
  localparam logic [SEL_W-1:0] W4_POWER = 3'h1;
  localparam logic [SEL_W-1:0] W4_DIGIN = 3'h2;
  localparam logic [SEL_W-1:0] W4_ANALOG2 = 3'h3;
  localparam logic [SEL_W-1:0] W4_HEATSINK = 3'h4;

  localparam word_t TORQUE_FULL = 16'h07D0;
  localparam word_t ANALOG_FULL = 16'h03E8;
  localparam word_t HEAT_FULL = 16'h03E8;

  localparam logic [IDX_W-1:0] PAR_NODE = 4'h1;
  localparam logic [IDX_W-1:0] PAR_CAN = 4'h2;
  localparam logic [IDX_W-1:0] PAR_SERIAL = 4'h3;
  localparam logic [IDX_W-1:0] PAR_FRAMING = 4'h4;
  localparam logic [IDX_W-1:0] PAR_WDOG = 4'h5;
  localparam logic [IDX_W-1:0] PAR_LOSS = 4'h6;
  localparam logic [IDX_W-1:0] PAR_RAMP = 4'h7;
  localparam logic [IDX_W-1:0] PAR_WORD4 = 4'h8;

  localparam logic [KIND_W-1:0] TG_CYCLIC = 2'h0;
  localparam logic [KIND_W-1:0] TG_WRITE = 2'h1;
  localparam logic [KIND_W-1:0] TG_READ = 2'h2;

  localparam logic [REG_W-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_W-1:0] REG_ADDR = 4'h1;
  localparam logic [REG_W-1:0] REG_CMD = 4'h2;
  localparam logic [REG_W-1:0] REG_DATA0 = 4'h3;
  localparam logic [REG_W-1:0] REG_DATA1 = 4'h4;
  localparam logic [REG_W-1:0] REG_LINK = 4'h5;
  localparam logic [REG_W-1:0] REG_RSPDATA = 4'h6;
  localparam logic [REG_W-1:0] REG_RSPWORD4 = 4'h7;
  localparam logic [REG_W-1:0] REG_STATUS = 4'h8;
  localparam logic [REG_W-1:0] REG_MASK = 4'h9;

  localparam int CMD_IDX_LSB = 4;
  localparam int LINK_FRM_LSB = 12;
  localparam int LINK_CAN_BIT = 15;
  localparam int ST_W = 3;
  localparam int ST_DONE = 0;
  localparam int ST_NAK = 1;
  localparam int ST_NOREPLY = 2;
  localparam int ST_BUSY_BIT = 15;
endpackage

/* File: logic/fieldbus_comms_device.sv */
// drive end: comms settings, loss watchdog and reaction, output word 4
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module fieldbus_comms_device #(
  parameter int unsigned WDOG_UNIT_CYC = fieldbus_cfg_pkg::WDOG_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  fieldbus_link_if.device link,
  input wire logic faultReset,
  input wire logic motorStopped,
  input wire fieldbus_cfg_pkg::word_t outputTorque,
  input wire fieldbus_cfg_pkg::word_t outputPower,
  input wire fieldbus_cfg_pkg::word_t digitalInputs,
  input wire fieldbus_cfg_pkg::word_t analogInput2,
  input wire fieldbus_cfg_pkg::word_t heatsinkTemp,
  input wire fieldbus_cfg_pkg::word_t accelRampTime,
  input wire fieldbus_cfg_pkg::word_t decelRampTime,
  output fieldbus_cfg_pkg::addr_t nodeAddressSetting,
  output fieldbus_cfg_pkg::rate_t canBitrateSetting,
  output fieldbus_cfg_pkg::rate_t serialBitrateSetting,
  output logic [fieldbus_cfg_pkg::FRM_W-1:0] serialFramingSetting,
  output logic commsLoss,
  output logic tripOut,
  output logic coastStop,
  output logic rampStop,
  output logic presetSpeed8Run,
  output fieldbus_cfg_pkg::word_t accelRamp,
  output fieldbus_cfg_pkg::word_t decelRamp
);
  import fieldbus_cfg_pkg::*;

  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_TRIPPED = 5'b00010,
    ST_RAMP_TRIP = 5'b00100,
    ST_RAMP_ONLY = 5'b01000,
    ST_PRESET = 5'b10000
  } react_e;

  addr_t node_q;
  rate_t canRate_q;
  rate_t serRate_q;
  logic [FRM_W-1:0] framing_q;
  logic [WDOG_W-1:0] wdogPeriod_q;
  logic [LOSS_W-1:0] lossReaction_q;
  logic rampSource_q;
  logic [SEL_W-1:0] word4Select_q;
  word_t fbAccel_q;
  word_t fbDecel_q;
  word_t accel_q;
  word_t decel_q;
  logic rspValid_q;
  logic rspNak_q;
  word_t rspData_q;
  word_t rspWord4_q;
  react_e state_q;
  react_e state_d;
  logic trip_q;
  logic coast_q;
  logic rampStop_q;
  logic preset_q;
  logic loss;
  logic lossPrev_q;
  logic lossRise;
  logic addrHit;
  logic linkMatch;
  logic tgGood;
  logic isWrite;
  logic isRead;
  logic wrOk;

  function automatic word_t sat(input word_t v, input word_t full);
    sat = (v > full) ? full : v;
  endfunction

  function automatic logic inRange(input logic [IDX_W-1:0] idx, input word_t d);
    case (idx)
      PAR_NODE: inRange = d <= 16'(NODE_MAX);
      PAR_CAN: inRange = d >= 16'(CAN_MIN) && d <= 16'(CAN_MAX);
      PAR_SERIAL: inRange = d >= 16'(SER_MIN) && d <= 16'(SER_MAX);
      PAR_FRAMING: inRange = d <= 16'(FRM_EVEN_1);
      PAR_WDOG: inRange = d <= 16'(WDOG_MAX);
      PAR_LOSS: inRange = d <= 16'(LOSS_PRESET8);
      PAR_RAMP: inRange = d <= 16'(RAMP_FIELDBUS);
      PAR_WORD4: inRange = d <= 16'(W4_HEATSINK);
      default: inRange = 1'b0;
    endcase
  endfunction

  function automatic logic knownIdx(input logic [IDX_W-1:0] idx);
    knownIdx = idx >= PAR_NODE && idx <= PAR_WORD4;
  endfunction

  assign addrHit = link.tgAddr == node_q;
  // a telegram at the wrong rate, or at the wrong framing on the serial link, is noise to this node
  assign linkMatch = link.tgCanMode ? (link.tgRate == canRate_q)
                                    : (link.tgRate == serRate_q
                                       && link.tgFraming == framing_q);
  assign tgGood = link.tgValid && addrHit && linkMatch
                  && (link.tgKind == TG_CYCLIC || link.tgKind == TG_WRITE
                      || link.tgKind == TG_READ);
  assign isWrite = tgGood && link.tgKind == TG_WRITE;
  assign isRead = tgGood && link.tgKind == TG_READ;
  assign wrOk = inRange(link.tgIndex, link.tgData0);

  always_ff @(posedge clk) begin
    if (srst) begin
      node_q <= NODE_DEF;
      canRate_q <= CAN_DEF;
      serRate_q <= SER_DEF;
      framing_q <= FRM_NONE_1;
      wdogPeriod_q <= WDOG_DEF;
      lossReaction_q <= LOSS_TRIP_COAST;
      rampSource_q <= RAMP_INTERNAL;
      word4Select_q <= W4_TORQUE;
    end else if (isWrite && wrOk) begin
      case (link.tgIndex)
        PAR_NODE: node_q <= link.tgData0[ADDR_W-1:0];
        PAR_CAN: canRate_q <= link.tgData0[RATE_W-1:0];
        PAR_SERIAL: serRate_q <= link.tgData0[RATE_W-1:0];
        PAR_FRAMING: framing_q <= link.tgData0[FRM_W-1:0];
        PAR_WDOG: wdogPeriod_q <= link.tgData0[WDOG_W-1:0];
        PAR_LOSS: lossReaction_q <= link.tgData0[LOSS_W-1:0];
        PAR_RAMP: rampSource_q <= link.tgData0[0];
        PAR_WORD4: word4Select_q <= link.tgData0[SEL_W-1:0];
        default: ;
      endcase
    end
  end

  // cyclic telegrams carry the fieldbus ramp times
  always_ff @(posedge clk) begin
    if (srst) begin
      fbAccel_q <= '0;
      fbDecel_q <= '0;
    end else if (tgGood && link.tgKind == TG_CYCLIC) begin
      fbAccel_q <= link.tgData0;
      fbDecel_q <= link.tgData1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      accel_q <= '0;
      decel_q <= '0;
    end else begin
      accel_q <= (rampSource_q == RAMP_FIELDBUS) ? fbAccel_q : accelRampTime;
      decel_q <= (rampSource_q == RAMP_FIELDBUS) ? fbDecel_q : decelRampTime;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rspValid_q <= 1'b0;
      rspNak_q <= 1'b0;
      rspData_q <= '0;
    end else begin
      rspValid_q <= tgGood;
      rspNak_q <= (isWrite && !wrOk) || (isRead && !knownIdx(link.tgIndex));
      rspData_q <= '0;
      if (isRead) begin
        case (link.tgIndex)
          PAR_NODE: rspData_q <= 16'(node_q);
          PAR_CAN: rspData_q <= 16'(canRate_q);
          PAR_SERIAL: rspData_q <= 16'(serRate_q);
          PAR_FRAMING: rspData_q <= 16'(framing_q);
          PAR_WDOG: rspData_q <= 16'(wdogPeriod_q);
          PAR_LOSS: rspData_q <= 16'(lossReaction_q);
          PAR_RAMP: rspData_q <= 16'(rampSource_q);
          PAR_WORD4: rspData_q <= 16'(word4Select_q);
          default: rspData_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rspWord4_q <= '0;
    end else begin
      case (word4Select_q)
        W4_TORQUE: rspWord4_q <= sat(outputTorque, TORQUE_FULL);
        W4_POWER: rspWord4_q <= outputPower;
        W4_DIGIN: rspWord4_q <= digitalInputs;
        W4_ANALOG2: rspWord4_q <= sat(analogInput2, ANALOG_FULL);
        W4_HEATSINK: rspWord4_q <= sat(heatsinkTemp, HEAT_FULL);
        default: rspWord4_q <= '0;
      endcase
    end
  end

  comms_watchdog #(
    .UNIT_CYC(WDOG_UNIT_CYC)
  ) watchdog (
    .clk(clk),
    .srst(srst),
    .kick(tgGood),
    .period(wdogPeriod_q),
    .loss(loss)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      lossPrev_q <= 1'b0;
    end else begin
      lossPrev_q <= loss;
    end
  end

  assign lossRise = loss && !lossPrev_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        if (lossRise) begin
          unique case (lossReaction_q)
            LOSS_TRIP_COAST: state_d = ST_TRIPPED;
            LOSS_RAMP_TRIP: state_d = ST_RAMP_TRIP;
            LOSS_RAMP_ONLY: state_d = ST_RAMP_ONLY;
            LOSS_PRESET8: state_d = ST_PRESET;
          endcase
        end
      end
      ST_RAMP_TRIP: begin
        if (motorStopped) begin
          state_d = ST_TRIPPED;
        end
      end
      ST_TRIPPED: begin
        // a trip only clears by reset once the link is healthy again
        if (faultReset && !loss) begin
          state_d = ST_RUN;
        end
      end
      ST_RAMP_ONLY, ST_PRESET: begin
        if (!loss) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_RUN;
      trip_q <= 1'b0;
      coast_q <= 1'b0;
      rampStop_q <= 1'b0;
      preset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      trip_q <= state_d == ST_TRIPPED;
      coast_q <= state_d == ST_TRIPPED;
      rampStop_q <= state_d == ST_RAMP_TRIP || state_d == ST_RAMP_ONLY;
      preset_q <= state_d == ST_PRESET;
    end
  end

  assign link.rspValid = rspValid_q;
  assign link.rspNak = rspNak_q;
  assign link.rspData = rspData_q;
  assign link.rspWord4 = rspWord4_q;
  assign nodeAddressSetting = node_q;
  assign canBitrateSetting = canRate_q;
  assign serialBitrateSetting = serRate_q;
  assign serialFramingSetting = framing_q;
  assign commsLoss = loss;
  assign tripOut = trip_q;
  assign coastStop = coast_q;
  assign rampStop = rampStop_q;
  assign presetSpeed8Run = preset_q;
  assign accelRamp = accel_q;
  assign decelRamp = decel_q;
endmodule // fieldbus_comms_device

/* File: logic/fieldbus_link_if.sv */
// telegram link between the network master and the drive
`timescale 1ns/1ps
interface fieldbus_link_if (
  input wire logic clk
);
  import fieldbus_cfg_pkg::*;
  logic tgValid;
  logic [KIND_W-1:0] tgKind;
  addr_t tgAddr;
  logic [IDX_W-1:0] tgIndex;
  word_t tgData0;
  word_t tgData1;
  logic tgCanMode;
  rate_t tgRate;
  logic [FRM_W-1:0] tgFraming;
  logic rspValid;
  logic rspNak;
  word_t rspData;
  word_t rspWord4;

  modport device (
    input clk, tgValid, tgKind, tgAddr, tgIndex, tgData0, tgData1, tgCanMode, tgRate,
    tgFraming,
    output rspValid, rspNak, rspData, rspWord4
  );
  modport master (
    input clk, rspValid, rspNak, rspData, rspWord4,
    output tgValid, tgKind, tgAddr, tgIndex, tgData0, tgData1, tgCanMode, tgRate,
    tgFraming
  );
endinterface

/* File: logic/fieldbus_master_end.sv */
// network master end: register-driven telegram launcher with interrupt
`timescale 1ns/1ps
module fieldbus_master_end (
  input wire logic clk,
  input wire logic srst,
  fieldbus_link_if.master link,
  input wire logic [fieldbus_cfg_pkg::REG_W-1:0] regAddr,
  input wire fieldbus_cfg_pkg::word_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output fieldbus_cfg_pkg::word_t regRdata,
  output logic irq
);
  import fieldbus_cfg_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } mst_e;
  localparam int WW = $clog2(RSP_WAIT_CYCLES + 1);
  localparam logic [WW-1:0] WAIT_LAST = WW'(RSP_WAIT_CYCLES);

  mst_e state_q;
  logic [WW-1:0] wait_q;
  logic tgValid_q;
  addr_t addr_q;
  logic [KIND_W-1:0] kind_q;
  logic [IDX_W-1:0] index_q;
  word_t data0_q;
  word_t data1_q;
  logic canMode_q;
  rate_t rate_q;
  logic [FRM_W-1:0] framing_q;
  word_t rspData_q;
  word_t rspWord4_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] setEv;
  word_t rdata_q;
  logic irq_q;
  logic launch;
  logic gotRsp;
  logic timedOut;

  assign launch = regWr && regAddr == REG_CTRL && regWdata[0] && state_q == ST_IDLE;
  assign gotRsp = state_q == ST_WAIT && link.rspValid;
  assign timedOut = state_q == ST_WAIT && !link.rspValid && wait_q == WAIT_LAST;

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_q <= NODE_DEF;
      kind_q <= TG_CYCLIC;
      index_q <= '0;
      data0_q <= '0;
      data1_q <= '0;
      canMode_q <= 1'b0;
      rate_q <= SER_DEF;
      framing_q <= FRM_NONE_1;
      mask_q <= '0;
    end else if (regWr && state_q == ST_IDLE) begin
      // telegram fields stay frozen while a telegram is in flight; the mask stays writable
      case (regAddr)
        REG_ADDR: addr_q <= regWdata[ADDR_W-1:0];
        REG_CMD: begin
          kind_q <= regWdata[KIND_W-1:0];
          index_q <= regWdata[CMD_IDX_LSB +: IDX_W];
        end
        REG_DATA0: data0_q <= regWdata;
        REG_DATA1: data1_q <= regWdata;
        REG_LINK: begin
          rate_q <= regWdata[RATE_W-1:0];
          framing_q <= regWdata[LINK_FRM_LSB +: FRM_W];
          canMode_q <= regWdata[LINK_CAN_BIT];
        end
        REG_MASK: mask_q <= regWdata[ST_W-1:0];
        default: ;
      endcase
    end else if (regWr && regAddr == REG_MASK) begin
      mask_q <= regWdata[ST_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      tgValid_q <= 1'b0;
      wait_q <= '0;
    end else begin
      tgValid_q <= launch;
      unique case (state_q)
        ST_IDLE: begin
          wait_q <= '0;
          if (launch) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_q <= wait_q + 1'b1;
          if (gotRsp || timedOut) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rspData_q <= '0;
      rspWord4_q <= '0;
    end else if (gotRsp) begin
      rspData_q <= link.rspData;
      rspWord4_q <= link.rspWord4;
    end
  end

  always_comb begin
    setEv = '0;
    setEv[ST_DONE] = gotRsp;
    setEv[ST_NAK] = gotRsp && link.rspNak;
    setEv[ST_NOREPLY] = timedOut;
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= '0;
    end else if (regWr && regAddr == REG_STATUS) begin
      status_q <= (status_q & ~regWdata[ST_W-1:0]) | setEv;
    end else begin
      status_q <= status_q | setEv;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_ADDR: rdata_q <= 16'(addr_q);
        REG_CMD: rdata_q <= 16'({index_q, 2'h0, kind_q});
        REG_DATA0: rdata_q <= data0_q;
        REG_DATA1: rdata_q <= data1_q;
        REG_LINK: rdata_q <= {canMode_q, 1'b0, framing_q, 1'b0, rate_q};
        REG_RSPDATA: rdata_q <= rspData_q;
        REG_RSPWORD4: rdata_q <= rspWord4_q;
        REG_STATUS: rdata_q <= {state_q == ST_WAIT, 12'h000, status_q};
        REG_MASK: rdata_q <= 16'(mask_q);
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign link.tgValid = tgValid_q;
  assign link.tgKind = kind_q;
  assign link.tgAddr = addr_q;
  assign link.tgIndex = index_q;
  assign link.tgData0 = data0_q;
  assign link.tgData1 = data1_q;
  assign link.tgCanMode = canMode_q;
  assign link.tgRate = rate_q;
  assign link.tgFraming = framing_q;
  assign regRdata = rdata_q;
  assign irq = irq_q;
endmodule // fieldbus_master_end

/* File: verif/fieldbus_link_properties.sv */
// protocol checker for the telegram link
`timescale 1ns/1ps
module fieldbus_link_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic tgValid,
  input wire logic [fieldbus_cfg_pkg::KIND_W-1:0] tgKind,
  input wire logic rspValid,
  input wire logic rspNak,
  input wire fieldbus_cfg_pkg::word_t rspData
);
  import fieldbus_cfg_pkg::*;
  default clocking
    @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence launch;
    tgValid ##1 !tgValid;
  endsequence
  sequence answer;
    tgValid ##1 rspValid;
  endsequence
  rsp_one_cycle_a: assert property (rspValid |=> !rspValid)
    else $error("reply longer than one cycle");
  rsp_cause_a: assert property (rspValid |-> $past(tgValid))
    else $error("reply without telegram");
  nak_with_rsp_a: assert property (rspNak |-> rspValid)
    else $error("nak outside reply");
  tg_pulse_a: assert property (tgValid |-> launch)
    else $error("telegram strobe too long");
  kind_unused_a: assert property (tgValid && tgKind == 2'h3 |=> !rspValid)
    else $error("reply to unused kind");
  cyclic_no_nak_a: assert property (tgValid && tgKind == TG_CYCLIC |=> !rspNak)
    else $error("cyclic telegram refused");
  write_data_zero_a: assert property (tgValid && tgKind == TG_WRITE ##1 rspValid
    |-> rspData == 16'h0000)
    else $error("write reply carries data");
  rsp_spacing_a: assert property (answer |-> !tgValid ##1 !tgValid)
    else $error("telegram too soon after reply");
endmodule // fieldbus_link_properties

/* File: verif/tb_fieldbus_comms_config_watchdog.sv */
// self-checking bench for master end and drive end
`timescale 1ns/1ps
module tb_fieldbus_comms_config_watchdog;
  import fieldbus_cfg_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  word_t regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  word_t regRdata;
  logic irq, faultReset = 1'b0, motorStopped = 1'b0;
  word_t tq = 16'h0000, pwr = 16'h0000, din = 16'h0000, an = 16'h0000, hs = 16'h0000;
  word_t acc = 16'h0000, dec = 16'h0000, accelRamp, decelRamp, st, rdat;
  addr_t node;
  rate_t canR, serR;
  logic [1:0] frm;
  logic loss, trip, coast, rstop, pre8;
  int mismatches = 0, compares = 0, cyc = 0, seed = 91198, m[9], i, v, lim;
  always #4 clk = ~clk;
  fieldbus_link_if bus (.clk(clk));
  fieldbus_master_end fieldbus_master_end_inst (.clk(clk), .srst(srst), .link(bus),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq));
  fieldbus_comms_device #(.WDOG_UNIT_CYC(10)) fieldbus_comms_device_inst (.clk(clk),
    .srst(srst), .link(bus), .faultReset(faultReset), .motorStopped(motorStopped),
    .outputTorque(tq), .outputPower(pwr), .digitalInputs(din), .analogInput2(an),
    .heatsinkTemp(hs), .accelRampTime(acc), .decelRampTime(dec),
    .nodeAddressSetting(node), .canBitrateSetting(canR), .serialBitrateSetting(serR),
    .serialFramingSetting(frm), .commsLoss(loss), .tripOut(trip), .coastStop(coast),
    .rampStop(rstop), .presetSpeed8Run(pre8), .accelRamp(accelRamp),
    .decelRamp(decelRamp));
  fieldbus_link_properties fieldbus_link_properties_inst (.clk(clk), .srst(srst),
    .tgValid(bus.tgValid), .tgKind(bus.tgKind), .rspValid(bus.rspValid),
    .rspNak(bus.rspNak), .rspData(bus.rspData));
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input string n, input word_t e, input word_t s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input word_t d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output word_t d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic send(input logic [1:0] k, input int p, input int d);
    int n;
    wr(REG_CMD, word_t'(p << 4 | k));
    wr(REG_DATA0, word_t'(d));
    wr(REG_CTRL, 16'h0001);
    n = 0;
    st = 16'h8000;
    while (st[15] && n < 40) begin
      rd(REG_STATUS, st);
      n++;
    end
    rd(REG_RSPDATA, rdat);
    wr(REG_STATUS, 16'h0007);
  endtask
  function automatic int bad(input int p, input int d);
    case (p)
      1: return d > 63;
      2: return d < 125 || d > 1000;
      3: return d < 96 || d > 1152;
      5: return d > 50;
      7: return d > 1;
      8: return d > 4;
      default: return d > 3;
    endcase
  endfunction
  task automatic pw(input int p, input int d);
    int e;
    e = bad(p, d);
    send(TG_WRITE, p, d);
    chk("reply", word_t'(e << 1), st & 16'h0006);
    if (e == 0)
      m[p] = d;
    wr(REG_ADDR, word_t'(m[1]));
    wr(REG_LINK, word_t'(m[4] << 12 | m[3]));
  endtask
  task automatic rb(input int p);
    send(TG_READ, p, 0);
    chk("readback", word_t'(m[p]), rdat);
  endtask
  task automatic react(input logic [3:0] e);
    chk("reaction", {12'h0, e}, {12'h0, trip, coast, rstop, pre8});
  endtask
  initial begin
    m = '{0, 1, 500, 1152, 0, 20, 0, 0, 0};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    chk("node", word_t'(NODE_DEF), word_t'(node));
    chk("can", word_t'(CAN_DEF), word_t'(canR));
    chk("serial", word_t'(SER_DEF), word_t'(serR));
    for (i = 1; i < 9; i++) rb(i);
    pw(5, 0);
    $display("defaults done");
    for (i = 0; i < 14; i++) begin
      v = $unsigned($random(seed)) % 7 + 1;
      v = v > 4 ? v + 1 : v;
      lim = v < 2 ? 70 : (v < 4 ? 1300 : 6);
      pw(v, $unsigned($random(seed)) % lim);
      rb(v);
      chk("cfg", word_t'(m[1] + m[2] + m[3] + m[4]), word_t'(node + canR + serR + frm));
    end
    for (i = 0; i < 4; i++) pw(4, i);
    wr(REG_LINK, word_t'(m[3]));
    send(TG_READ, 1, 0);
    chk("framing mismatch", 16'h0004, st & 16'h0006);
    wr(REG_LINK, word_t'(m[4] << 12 | m[3]));
    wr(REG_ADDR, word_t'(m[1] ^ 1));
    send(TG_READ, 1, 0);
    chk("wrong node", 16'h0004, st & 16'h0006);
    wr(REG_ADDR, word_t'(m[1]));
    wr(REG_LINK, word_t'(16'h8000 | m[2]));
    send(TG_READ, 2, 0);
    chk("can link", word_t'(m[2]), rdat);
    wr(REG_LINK, word_t'(16'h8000 | m[2] ^ 1));
    send(TG_READ, 2, 0);
    chk("can rate mismatch", 16'h0004, st & 16'h0006);
    wr(REG_LINK, word_t'(m[4] << 12 | m[3]));
    send(2'h3, 1, 0);
    chk("unused kind", 16'h0004, st & 16'h0006);
    pw(1, 63);
    $display("settings done");
    acc <= word_t'($random(seed));
    dec <= word_t'($random(seed));
    pw(7, 1);
    v = $random(seed) & 16'hFFFF;
    wr(REG_DATA1, word_t'(v ^ 16'h5A5A));
    send(TG_CYCLIC, 0, v);
    chk("bus accel", word_t'(v), accelRamp);
    chk("bus decel", word_t'(v ^ 16'h5A5A), decelRamp);
    pw(7, 0);
    chk("own accel", acc, accelRamp);
    chk("own decel", dec, decelRamp);
    $display("ramp done");
    for (i = 0; i < 5; i++) begin
      pw(8, i);
      tq <= word_t'($unsigned($random(seed)) % 3000);
      pwr <= word_t'($random(seed));
      din <= word_t'($random(seed));
      an <= word_t'($unsigned($random(seed)) % 1500);
      hs <= word_t'($unsigned($random(seed)) % 1500);
      send(TG_CYCLIC, 0, 0);
      rd(REG_RSPWORD4, rdat);
      case (i)
        0: chk("torque", tq > 2000 ? TORQUE_FULL : tq, rdat);
        1: chk("power", pwr, rdat);
        2: chk("inputs", din, rdat);
        3: chk("analog", an > 1000 ? ANALOG_FULL : an, rdat);
        default: chk("heatsink", hs > 1000 ? HEAT_FULL : hs, rdat);
      endcase
    end
    $display("word4 done");
    for (i = 0; i < 4; i++) begin
      pw(5, 0);
      pw(6, i);
      pw(5, 1);
      repeat (30) @(posedge clk);
      chk("loss", 16'h0001, {15'h0, loss});
      react(i == 0 ? 4'hC : (i == 3 ? 4'h1 : 4'h2));
      motorStopped <= 1'b1;
      repeat (4) @(posedge clk);
      if (i == 1) react(4'hC);
      pw(5, 0);
      faultReset <= 1'b1;
      motorStopped <= 1'b0;
      repeat (3) @(posedge clk);
      faultReset <= 1'b0;
      repeat (3) @(posedge clk);
      react(4'h0);
    end
    $display("watchdog done");
    wr(REG_MASK, 16'h0001);
    wr(REG_CTRL, 16'h0001);
    repeat (8) @(posedge clk);
    chk("irq set", 16'h0001, {15'h0, irq});
    wr(REG_MASK, 16'h0000);
    repeat (2) @(posedge clk);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(REG_MASK, 16'h0001);
    wr(REG_STATUS, 16'h0007);
    repeat (2) @(posedge clk);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    rd(4'hF, rdat);
    chk("unmapped", 16'h0000, rdat);
    $display("master regs done");
    stop_test();
  end
endmodule // tb_fieldbus_comms_config_watchdog
